/* pkg/isf_map.svh */
// register offsets, field positions, reset values and fixed figures of the sensor data filter
`ifndef ISF_MAP_SVH
`define ISF_MAP_SVH

`define ISF_FCTL_ADDR      8'h06
`define ISF_FCTL_RST       16'h0000
`define ISF_FCTL_SEL_LSB   0
`define ISF_FCTL_SEL_W     5
`define ISF_FCTL_BUSY_BIT  8
`define ISF_FCTL_BAD_BIT   9
`define ISF_SEL_BYPASS     5'h00
`define ISF_SEL_MA_LAST    5'h07
`define ISF_SEL_FIR_FIRST  5'h08
`define ISF_SEL_FIR_LAST   5'h13
`define ISF_FIR_LOG2_MIN   3'h5
`define ISF_KAISER_BETA    8
`define ISF_FC_RATIO_MAX   8'h14
`define ISF_SETTLE_MAX     8'h7F
`define ISF_COEF_FRAC      15
`define ISF_FC_STEP_Q15    16'h0666
`define ISF_INV_PI_Q15     16'h28BE

`endif

/* pkg/isf_pkg.sv */
// types shared by the sensor data filter modules
package isf_pkg;

   typedef enum logic [1:0] {
      ISF_IDLE = 2'b00,
      ISF_ACC  = 2'b01,
      ISF_OUT  = 2'b10
   } isf_state_e;

   typedef logic [4:0]         isf_sel_t;
   typedef logic signed [15:0] isf_sample_t;

endpackage

/* pkg/isf_stream_if.sv */
// valid/ready sample stream between the filter's own modules
`timescale 1ns/1ps
interface isf_stream_if #(
   parameter int W = 16
);
   logic         valid;
   logic         ready;
   logic [W-1:0] data;

   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface

/* design/isf_fifo.sv */
// sample FIFO in front of the filter engine
`timescale 1ns/1ps
module isf_fifo #(
   parameter int W = 16,
   parameter int D = 16
) (
   // clock and reset
   input  wire logic    i_core_clk,
   input  wire logic    i_reset,
   input  wire logic    i_ce,
   // streams
   isf_stream_if.snk    in_s,
   isf_stream_if.src    out_s
);
   localparam int AW = $clog2(D);

   typedef struct packed {
      logic [D-1:0][W-1:0] mem;
      logic [AW-1:0]       wp;
      logic [AW-1:0]       rp;
      logic [AW:0]         cnt;
   } isf_fifo_s;

   isf_fifo_s r_r;
   isf_fifo_s r_nxt;
   logic      push;
   logic      pop;

   assign in_s.ready  = (r_r.cnt != (AW+1)'(D));
   assign out_s.valid = (r_r.cnt != '0);
   assign out_s.data  = r_r.mem[r_r.rp];
   assign push        = in_s.valid && in_s.ready;
   assign pop         = out_s.valid && out_s.ready;

   always_comb begin
      r_nxt = r_r;
      if (push) begin
         r_nxt.mem[r_r.wp] = in_s.data;
         r_nxt.wp          = (r_r.wp == AW'(D-1)) ? '0 : r_r.wp + 1'b1;
      end
      if (pop) begin
         r_nxt.rp = (r_r.rp == AW'(D-1)) ? '0 : r_r.rp + 1'b1;
      end
      case ({push, pop})
         2'b10:   r_nxt.cnt = r_r.cnt + 1'b1;
         2'b01:   r_nxt.cnt = r_r.cnt - 1'b1;
         default: r_nxt.cnt = r_r.cnt;
      endcase
   end

   always_ff @(posedge i_core_clk) begin
      if (i_reset) begin
         r_r <= '0;
      end else if (i_ce) begin
         r_r <= r_nxt;
      end
   end
endmodule

/* design/isf_coef.sv */
// windowed-sinc low-pass coefficient for one tap, computed on the fly
`timescale 1ns/1ps
`include "isf_map.svh"
module isf_coef (
   // tap selection
   input  wire logic [6:0]         i_k,
   input  wire logic [2:0]         i_log2n,
   input  wire logic [3:0]         i_fc_m,
   // result, Q15
   output logic signed [15:0]      o_coef
);
   // half of a Kaiser window with shape 8, sampled at |d|/(N/2) = j/16
   function automatic logic [15:0] kaiser8(input logic [4:0] j);
      case (j)
         5'h00: kaiser8 = 16'h7FFF;  5'h01: kaiser8 = 16'h7E04;
         5'h02: kaiser8 = 16'h78B4;  5'h03: kaiser8 = 16'h6FFE;
         5'h04: kaiser8 = 16'h64DC;  5'h05: kaiser8 = 16'h57EE;
         5'h06: kaiser8 = 16'h4A1A;  5'h07: kaiser8 = 16'h3C46;
         5'h08: kaiser8 = 16'h2F1C;  5'h09: kaiser8 = 16'h2332;
         5'h0A: kaiser8 = 16'h1914;  5'h0B: kaiser8 = 16'h10C2;
         5'h0C: kaiser8 = 16'h0A82;  5'h0D: kaiser8 = 16'h0604;
         5'h0E: kaiser8 = 16'h02EE;  5'h0F: kaiser8 = 16'h0140;
         default: kaiser8 = 16'h004D;
      endcase
   endfunction

   // quarter sine, 40 steps per turn
   function automatic logic [15:0] qsin(input logic [3:0] j);
      case (j)
         4'h0: qsin = 16'h0000;  4'h1: qsin = 16'h1406;  4'h2: qsin = 16'h278E;
         4'h3: qsin = 16'h3A1C;  4'h4: qsin = 16'h4B3D;  4'h5: qsin = 16'h5A82;
         4'h6: qsin = 16'h678D;  4'h7: qsin = 16'h720C;  4'h8: qsin = 16'h79BC;
         4'h9: qsin = 16'h7E6D;  default: qsin = 16'h7FFF;
      endcase
   endfunction

   logic signed [7:0]  d;
   logic [6:0]         ad;
   logic [9:0]         ph;
   logic [3:0]         j;
   logic signed [31:0] sv;
   logic signed [31:0] h;
   logic signed [47:0] prod;
   logic [11:0]        widx;

   always_comb begin
      d    = $signed({1'b0, i_k}) - $signed(8'(8'h01 << (i_log2n - 3'h1)));
      ad   = d[7] ? 7'(-d) : d[6:0];
      ph   = 10'((11'(i_fc_m) * 11'(ad)) % 11'd40);
      j    = 4'(ph % 10'd10);
      case (ph / 10'd10)
         10'd0:   sv = 32'(qsin(j));
         10'd1:   sv = 32'(qsin(4'd10 - j));
         10'd2:   sv = -32'(qsin(j));
         default: sv = -32'(qsin(4'd10 - j));
      endcase
      // the sinc limit at the centre tap is 2*fc/fs
      if (ad == '0) begin
         h = 32'(i_fc_m) * 32'(`ISF_FC_STEP_Q15);
      end else begin
         h = ((sv / 32'(ad)) * 32'(`ISF_INV_PI_Q15)) >>> `ISF_COEF_FRAC;
      end
      widx   = 12'((12'(ad) << 5) >> i_log2n);
      prod   = 48'(h) * 48'(kaiser8(widx[4:0]));             // RULE3
      o_coef = 16'(prod >>> `ISF_COEF_FRAC);
   end
endmodule

/* design/isf_filter.sv */
// sensor data filter: moving average or Kaiser FIR over the raw sample stream
`timescale 1ns/1ps
`include "isf_map.svh"
// Notes on behaviour
// (RULE1) The filter type and tap count come from the filter control register at offset 0x06.
// (RULE2) Moving-average mode averages 2, 4, 8, 16, 32, 64 or 128 consecutive input samples.
// (RULE3) FIR coefficients are shaped by a Kaiser window with shape parameter eight.
// (RULE4) FIR mode offers 32, 64 or 128 taps, each with a 50, 100, 200 or 400 Hz cutoff.
// (RULE5) Settling after sampling starts never exceeds 127 output samples and depends on rate and taps.
// (RULE6) Moving-average settling follows the rate-versus-tap table, e.g. 127, 63 and 25 at 128 taps.
// (RULE7) The host uses only valid rate and tap pairings; at 15.625 sps only the 128-tap average.
// (RULE8) FIR settling at 2000 sps is 31, 63 or 127 output samples for 32, 64 or 128 taps.
// (RULE9) An external trigger driving sampling must run at 15.625 Hz or faster.
module isf_filter #(
   parameter int FIFO_DEPTH = 16,
   parameter int HIST_DEPTH = 128
) (
   // clock, reset, enable
   input  wire logic        i_core_clk,
   input  wire logic        i_reset,
   input  wire logic        i_ce,
   // register port
   input  wire logic        i_reg_wr,
   input  wire logic        i_reg_rd,
   input  wire logic [7:0]  i_reg_addr,
   input  wire logic [15:0] i_reg_wdata,
   output logic [15:0]      o_reg_rdata,
   // sampling context
   input  wire logic        i_sampling,
   input  wire logic [3:0]  i_dout_rate,
   // raw samples in
   input  wire logic        i_smp_valid,
   input  wire logic [15:0] i_smp_data,
   output logic             o_smp_ready,
   // filtered samples out
   output logic             o_flt_valid,
   output logic [15:0]      o_flt_data,
   input  wire logic        i_flt_ready,
   output logic             o_flt_settled,
   output logic             o_cfg_invalid
);
   typedef struct packed {
      isf_pkg::isf_state_e             st;
      logic [HIST_DEPTH-1:0][15:0]     hist;
      logic [6:0]                      wp;
      logic [6:0]                      k;
      logic signed [39:0]              acc;
      logic [15:0]                     out_data;
      isf_pkg::isf_sel_t               sel;
      logic                            samp_d;
      logic [7:0]                      ocnt;
      logic [7:0]                      dcnt;
      logic [15:0]                     rdata;
   } isf_top_s;

   // log2 of the tap count, 0 meaning no filtering
   function automatic logic [2:0] sel_log2n(input isf_pkg::isf_sel_t s);
      if (s <= `ISF_SEL_MA_LAST) begin
         sel_log2n = s[2:0];                                   // RULE2
      end else if (s <= `ISF_SEL_FIR_LAST) begin
         sel_log2n = `ISF_FIR_LOG2_MIN + 3'((s - `ISF_SEL_FIR_FIRST) >> 2); // RULE4
      end else begin
         sel_log2n = 3'h0;
      end
   endfunction

   function automatic logic is_fir(input isf_pkg::isf_sel_t s);
      is_fir = (s >= `ISF_SEL_FIR_FIRST) && (s <= `ISF_SEL_FIR_LAST);
   endfunction

   // cutoff as a multiple of 50 Hz
   function automatic logic [3:0] fc_mult(input isf_pkg::isf_sel_t s);
      fc_mult = 4'(4'h1 << 2'(s - `ISF_SEL_FIR_FIRST));        // RULE4
   endfunction

   // input samples per output sample, 2000 sps down to 15.625 sps
   function automatic logic [7:0] decim_ratio(input logic [3:0] c);
      case (c)
         4'h0: decim_ratio = 8'h01;  4'h1: decim_ratio = 8'h02;
         4'h2: decim_ratio = 8'h04;  4'h3: decim_ratio = 8'h05;
         4'h4: decim_ratio = 8'h08;  4'h5: decim_ratio = 8'h0A;
         4'h6: decim_ratio = 8'h10;  4'h7: decim_ratio = 8'h14;
         4'h8: decim_ratio = 8'h19;  4'h9: decim_ratio = 8'h20;
         4'hA: decim_ratio = 8'h28;  4'hB: decim_ratio = 8'h32;
         4'hC: decim_ratio = 8'h40;  4'hD: decim_ratio = 8'h50;
         4'hE: decim_ratio = 8'h64;  default: decim_ratio = 8'h80;
      endcase
   endfunction

   // transient in output samples: (taps - 1) / ratio, which reproduces both tables
   function automatic logic [7:0] settle_len(input isf_pkg::isf_sel_t s, input logic [3:0] c);
      logic [7:0] n;
      n          = 8'(8'h01 << sel_log2n(s));
      settle_len = (n - 8'h01) / decim_ratio(c);                // RULE5 RULE6 RULE8
      if (settle_len > `ISF_SETTLE_MAX) begin
         settle_len = `ISF_SETTLE_MAX;
      end
   endfunction

   // pairings the host is allowed to choose
   function automatic logic cfg_ok(input isf_pkg::isf_sel_t s, input logic [3:0] c);
      logic [7:0]  n;
      logic [11:0] fm;
      n  = 8'(8'h01 << sel_log2n(s));
      fm = 12'(fc_mult(s)) * 12'(decim_ratio(c));
      if (s > `ISF_SEL_FIR_LAST) begin
         cfg_ok = 1'b0;
      end else if (is_fir(s)) begin
         cfg_ok = (fm <= 12'(`ISF_FC_RATIO_MAX));
      end else begin
         cfg_ok = (decim_ratio(c) <= n);                        // RULE7
      end
   endfunction

   function automatic logic [15:0] sat16(input logic signed [39:0] v);
      if (v > 40'sh0000007FFF) begin
         sat16 = 16'h7FFF;
      end else if (v < -40'sh0000008000) begin
         sat16 = 16'h8000;
      end else begin
         sat16 = v[15:0];
      end
   endfunction

   isf_top_s          r_r;
   isf_top_s          r_nxt;
   logic [2:0]        log2n;
   logic [7:0]        settle;
   logic              settled;
   logic              fctl_wr;
   logic              restart;
   logic signed [15:0] coef;
   logic [15:0]       tap_smp;

   isf_stream_if #(.W(16)) in_if ();
   isf_stream_if #(.W(16)) eng_if ();

   assign in_if.valid = i_smp_valid;
   assign in_if.data  = i_smp_data;
   assign o_smp_ready = in_if.ready;

   // the FIFO soaks up the burst while the MAC loop runs one tap per cycle
   isf_fifo #(
      .W (16),
      .D (FIFO_DEPTH)
   ) u_fifo (
      .i_core_clk (i_core_clk),
      .i_reset    (i_reset),
      .i_ce       (i_ce),
      .in_s       (in_if.snk),
      .out_s      (eng_if.src)
   );

   isf_coef u_coef (
      .i_k     (r_r.k),
      .i_log2n (log2n),
      .i_fc_m  (fc_mult(r_r.sel)),
      .o_coef  (coef)
   );

   assign log2n   = sel_log2n(r_r.sel);                        // RULE1
   assign settle  = settle_len(r_r.sel, i_dout_rate);
   assign settled = (r_r.ocnt >= settle);
   assign fctl_wr = i_reg_wr && (i_reg_addr == `ISF_FCTL_ADDR);
   // a new setting or a fresh start of sampling throws away old history
   assign restart = fctl_wr || (i_sampling && !r_r.samp_d);
   assign tap_smp = r_r.hist[7'(r_r.wp - 7'h01 - r_r.k)];

   assign eng_if.ready  = (r_r.st == isf_pkg::ISF_IDLE) && i_sampling && !restart;
   assign o_flt_valid   = (r_r.st == isf_pkg::ISF_OUT);
   assign o_flt_data    = r_r.out_data;
   assign o_flt_settled = settled;
   assign o_cfg_invalid = !cfg_ok(r_r.sel, i_dout_rate);
   assign o_reg_rdata   = r_r.rdata;

   always_comb begin
      r_nxt        = r_r;
      r_nxt.samp_d = i_sampling;
      if (i_reg_rd) begin
         r_nxt.rdata = 16'h0000;
         if (i_reg_addr == `ISF_FCTL_ADDR) begin
            r_nxt.rdata[`ISF_FCTL_SEL_LSB +: `ISF_FCTL_SEL_W] = r_r.sel;
            r_nxt.rdata[`ISF_FCTL_BUSY_BIT] = !settled;
            r_nxt.rdata[`ISF_FCTL_BAD_BIT]  = o_cfg_invalid;
         end
      end
      case (r_r.st)
         isf_pkg::ISF_IDLE: begin
            if (eng_if.valid && eng_if.ready) begin
               r_nxt.hist[r_r.wp] = eng_if.data;
               r_nxt.wp           = r_r.wp + 7'h01;
               r_nxt.k            = 7'h00;
               r_nxt.acc          = '0;
               if (log2n == 3'h0) begin
                  r_nxt.out_data = eng_if.data;
                  r_nxt.st       = isf_pkg::ISF_OUT;
               end else begin
                  r_nxt.st = isf_pkg::ISF_ACC;
               end
            end
         end
         isf_pkg::ISF_ACC: begin
            if (is_fir(r_r.sel)) begin
               r_nxt.acc = r_r.acc + 40'($signed(tap_smp) * coef);  // RULE3 RULE4
            end else begin
               r_nxt.acc = r_r.acc + 40'($signed(tap_smp));        // RULE2
            end
            r_nxt.k = r_r.k + 7'h01;
            if (r_r.k == 7'((8'h01 << log2n) - 8'h01)) begin
               r_nxt.st = isf_pkg::ISF_OUT;
               if (is_fir(r_r.sel)) begin
                  r_nxt.out_data = sat16(r_nxt.acc >>> `ISF_COEF_FRAC);
               end else begin
                  r_nxt.out_data = sat16(r_nxt.acc >>> log2n);
               end
            end
         end
         isf_pkg::ISF_OUT: begin
            if (i_flt_ready) begin
               r_nxt.st = isf_pkg::ISF_IDLE;
               // every ratio-th filtered sample becomes an output sample downstream
               if (r_r.dcnt + 8'h01 >= decim_ratio(i_dout_rate)) begin
                  r_nxt.dcnt = 8'h00;
                  if (r_r.ocnt != 8'hFF) begin
                     r_nxt.ocnt = r_r.ocnt + 8'h01;                // RULE5
                  end
               end else begin
                  r_nxt.dcnt = r_r.dcnt + 8'h01;
               end
            end
         end
         default: r_nxt.st = isf_pkg::ISF_IDLE;
      endcase
      if (restart) begin
         r_nxt.st   = isf_pkg::ISF_IDLE;
         r_nxt.hist = '0;
         r_nxt.wp   = 7'h00;
         r_nxt.k    = 7'h00;
         r_nxt.acc  = '0;
         r_nxt.ocnt = 8'h00;
         r_nxt.dcnt = 8'h00;
      end
      if (fctl_wr) begin
         r_nxt.sel = i_reg_wdata[`ISF_FCTL_SEL_LSB +: `ISF_FCTL_SEL_W]; // RULE1
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (i_reset) begin
         r_r       <= '0;
         r_r.sel   <= isf_pkg::isf_sel_t'(`ISF_FCTL_RST);
      end else if (i_ce) begin
         r_r <= r_nxt;
      end
   end
endmodule

/* tb/isf_filter_assertions.sv */
// concurrent checks on the sensor data filter ports
`timescale 1ns/1ps
module isf_filter_assertions #(
   parameter int FIFO_DEPTH = 16,
   parameter int HIST_DEPTH = 128
) (
   // clock and reset
   input wire logic        i_core_clk,
   input wire logic        i_reset,
   input wire logic        i_ce,
   // register port
   input wire logic        i_reg_wr,
   input wire logic        i_reg_rd,
   input wire logic [7:0]  i_reg_addr,
   input wire logic [15:0] i_reg_wdata,
   input wire logic [15:0] o_reg_rdata,
   // stream and status
   input wire logic        i_sampling,
   input wire logic [3:0]  i_dout_rate,
   input wire logic        o_flt_valid,
   input wire logic [15:0] o_flt_data,
   input wire logic        i_flt_ready,
   input wire logic        o_flt_settled,
   input wire logic        o_cfg_invalid
);
   wire wr6 = i_ce && i_reg_wr && i_reg_addr == 8'h06;
   wire rd6 = i_ce && i_reg_rd && i_reg_addr == 8'h06;
   default clocking cb @(posedge i_core_clk);
   endclocking
   default disable iff (i_reset);
   unmapped_read_a: assert property (i_ce && i_reg_rd && i_reg_addr != 8'h06 |=> o_reg_rdata == 16'h0000)
      else $error("unmapped read returned data");
   busy_flag_a: assert property (rd6 |=> o_reg_rdata[8] == !$past(o_flt_settled))
      else $error("settling flag differs from settled output");
   sel_readback_a: assert property (wr6 ##1 rd6 |=> o_reg_rdata[4:0] == $past(i_reg_wdata[4:0], 2))
      else $error("filter selection not read back");
   restart_abort_a: assert property (wr6 |=> !o_flt_valid)
      else $error("pending output survived a reconfiguration");
   output_hold_a: assert property (o_flt_valid && !i_flt_ready && !wr6 && $stable(i_sampling)
      |=> o_flt_valid && $stable(o_flt_data)) else $error("output dropped before acceptance");
   ma128_settle_a: assert property (wr6 && i_reg_wdata[4:0] == 5'h07 && i_dout_rate == 4'h0
      ##1 i_dout_rate == 4'h0 |-> !o_flt_settled) else $error("long average reported settled at once");
   bypass_settled_a: assert property (wr6 && i_reg_wdata[4:0] == 5'h00 |=> o_flt_settled)
      else $error("bypass not settled");
   fir_slow_a: assert property (wr6 && i_reg_wdata[4:0] inside {[5'h08:5'h13]} && i_dout_rate == 4'hF
      ##1 i_dout_rate == 4'hF |-> o_cfg_invalid) else $error("fir at slowest rate not flagged");
endmodule
bind isf_filter isf_filter_assertions #(.FIFO_DEPTH(FIFO_DEPTH), .HIST_DEPTH(HIST_DEPTH)) i_chk (
   .i_core_clk(i_core_clk), .i_reset(i_reset), .i_ce(i_ce), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
   .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata), .i_sampling(i_sampling),
   .i_dout_rate(i_dout_rate), .o_flt_valid(o_flt_valid), .o_flt_data(o_flt_data), .i_flt_ready(i_flt_ready),
   .o_flt_settled(o_flt_settled), .o_cfg_invalid(o_cfg_invalid));

/* tb/isf_partner.sv */
// far side model: raw sample source and filtered sample sink
`timescale 1ns/1ps
module isf_partner (
   // clock
   input  wire logic        i_core_clk,
   // raw sample source
   input  wire logic        i_smp_ready,
   output logic             o_smp_valid,
   output logic [15:0]      o_smp_data,
   // filtered sample sink
   input  wire logic        i_flt_valid,
   input  wire logic [15:0] i_flt_data,
   output logic             o_flt_ready
);
   int stall = 0;
   initial begin
      o_smp_valid = 1'b0;
      o_smp_data  = 16'h0000;
      o_flt_ready = 1'b0;
   end
   // called just after an edge; ready only moves on edges, so a look now predicts the next edge
   // samples come back to back, far faster than the slowest allowed trigger pace
   task automatic put(input logic [15:0] d, output bit ok);
      ok = 0;
      o_smp_valid = 1'b1;
      o_smp_data  = d;
      for (int n = 0; n < 400 && !ok; n++) begin
         ok = i_smp_ready;
         @(posedge i_core_clk);
         #1;
      end
      o_smp_valid = 1'b0;
      // released line shows the inverse so a stale word can never pass for a new one
      o_smp_data  = ~d;
   endtask
   // sink holds off for stall cycles first, to make the filter keep its output up
   task automatic take(output logic [15:0] d, output bit ok);
      ok = 0;
      for (int n = 0; n < 400 && !ok; n++) begin
         o_flt_ready = (n >= stall);
         if (i_flt_valid === 1'b1 && o_flt_ready) begin
            d  = i_flt_data;
            ok = 1;
         end
         @(posedge i_core_clk);
         #1;
      end
      o_flt_ready = 1'b0;
   endtask
endmodule

/* tb/test_isf_filter.sv */
// self-checking bench of the sensor data filter
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin checks_done++; if ((got) !== (exp)) begin miscompares++; \
   $display("wrong value %s expected %h seen %h", nm, exp, got); end end
module test_isf_filter;
   logic        i_core_clk;
   logic        i_reset;
   logic        i_reg_wr;
   logic        i_reg_rd;
   logic [7:0]  i_reg_addr;
   logic [15:0] i_reg_wdata;
   logic [15:0] o_reg_rdata;
   logic        i_sampling;
   logic        i_ce;
   logic [3:0]  i_dout_rate;
   logic        smp_valid, smp_ready, flt_valid, flt_ready, flt_settled, cfg_invalid;
   logic [15:0] smp_data, flt_data;
   int          miscompares = 0;
   int          checks_done = 0;
   isf_filter i_dut (.i_core_clk(i_core_clk), .i_reset(i_reset), .i_ce(i_ce), .i_reg_wr(i_reg_wr),
      .i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
      .i_sampling(i_sampling), .i_dout_rate(i_dout_rate), .i_smp_valid(smp_valid), .i_smp_data(smp_data),
      .o_smp_ready(smp_ready), .o_flt_valid(flt_valid), .o_flt_data(flt_data), .i_flt_ready(flt_ready),
      .o_flt_settled(flt_settled), .o_cfg_invalid(cfg_invalid));
   isf_partner i_far (.i_core_clk(i_core_clk), .i_smp_ready(smp_ready), .o_smp_valid(smp_valid),
      .o_smp_data(smp_data), .i_flt_valid(flt_valid), .i_flt_data(flt_data), .o_flt_ready(flt_ready));
   task automatic close_out;
      if (miscompares == 0 && checks_done > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic bounded(input bit ok);
      `CHK("handshake done", 1'b1, ok)
      if (!ok) close_out();
   endtask
   task automatic reg_wr(input logic [15:0] d);
      i_reg_wr    = 1'b1;
      i_reg_addr  = 8'h06;
      i_reg_wdata = d;
      @(posedge i_core_clk);
      #1;
      i_reg_wr = 1'b0;
   endtask
   task automatic reg_rd(input logic [7:0] a, output logic [15:0] d);
      i_reg_rd   = 1'b1;
      i_reg_addr = a;
      @(posedge i_core_clk);
      #1;
      i_reg_rd = 1'b0;
      d = o_reg_rdata;
   endtask
   task automatic send(input logic [15:0] d, output logic [15:0] y);
      bit ok;
      i_far.put(d, ok);
      bounded(ok);
      i_far.take(y, ok);
      bounded(ok);
   endtask
   task automatic t_regs;
      logic [15:0] d;
      reg_rd(8'h06, d);
      `CHK("control reset", 16'h0000, d)
      reg_rd(8'h07, d);
      `CHK("unmapped read", 16'h0000, d)
      reg_wr(16'hFFE7);
      reg_rd(8'h06, d);
      `CHK("ma128 unsettled", 16'h0107, d)
      // a write while the enable is low must leave the setting alone
      i_ce = 1'b0;
      reg_wr(16'h0003);
      i_ce = 1'b1;
      reg_rd(8'h06, d);
      `CHK("frozen write", 16'h0107, d)
   endtask
   task automatic t_fifo;
      logic [15:0] y;
      bit ok;
      reg_wr(16'h0000);
      for (int k = 0; k < 16; k++) begin
         i_far.put(16'hA000 + 16'(k), ok);
         bounded(ok);
      end
      `CHK("fifo full", 1'b0, smp_ready)
      i_sampling = 1'b1;
      i_far.stall = 2;
      for (int k = 0; k < 16; k++) begin
         i_far.take(y, ok);
         bounded(ok);
         `CHK("bypass word", 16'hA000 + 16'(k), y)
      end
      i_far.stall = 0;
   endtask
   task automatic t_ma;
      logic [15:0] y;
      for (int s = 1; s < 8; s++) begin
         reg_wr(16'(s));
         send(16'hFC00, y);
         `CHK("ma first", 16'($signed(16'hFC00) >>> s), y)
         for (int k = 1; k < (1 << s); k++) send(16'hFC00, y);
         `CHK("ma full", 16'hFC00, y)
      end
   endtask
   task automatic t_settle;
      logic [15:0] y;
      int rate [3] = '{0, 1, 3};
      int len [3]  = '{127, 63, 25};
      int div [3]  = '{1, 2, 5};
      for (int r = 0; r < 3; r++) begin
         i_dout_rate = 4'(rate[r]);
         reg_wr(16'h0007);
         for (int k = 1; k < len[r] * div[r]; k++) send(16'h0010, y);
         `CHK("ma not settled", 1'b0, flt_settled)
         send(16'h0010, y);
         `CHK("ma settled", 1'b1, flt_settled)
      end
   endtask
   task automatic t_fir;
      logic [15:0] d;
      i_dout_rate = 4'h0;
      for (int s = 8; s < 20; s++) begin
         reg_wr(16'(s));
         reg_rd(8'h06, d);
         `CHK("fir control", 16'h0100 | 16'(s), d)
      end
      reg_wr(16'h0008);
      for (int k = 1; k < 31; k++) send(16'h0100, d);
      `CHK("fir not settled", 1'b0, flt_settled)
      send(16'h0100, d);
      `CHK("fir settled", 1'b1, flt_settled)
      i_dout_rate = 4'hF;
      reg_wr(16'h0008);
      reg_rd(8'h06, d);
      `CHK("fir slow flag", 1'b1, d[9])
      `CHK("cfg invalid pin", 1'b1, cfg_invalid)
   endtask
   initial begin
      i_core_clk = 1'b0;
      forever #2.5 i_core_clk = ~i_core_clk;
   end
   initial begin
      i_reset     = 1'b1;
      i_ce        = 1'b1;
      i_reg_wr    = 1'b0;
      i_reg_rd    = 1'b0;
      i_reg_addr  = 8'h00;
      i_reg_wdata = 16'h0000;
      i_sampling  = 1'b0;
      i_dout_rate = 4'h0;
      repeat (2) @(posedge i_core_clk);
      #1;
      i_reset = 1'b0;
      t_regs();
      t_fifo();
      t_ma();
      t_settle();
      t_fir();
      close_out();
   end
endmodule
